// file: hw/opt_cfg_pkg.sv
/*
 Constants, register map, state codes and field layout for the option byte
 loader and supply-monitor reset sequencer.
 Assumes a 100 MHz mclk and an APB register port with 32-bit data.
*/
package opt_cfg_pkg;

   // Option area in storage and its byte indices
   localparam logic [19:0] OPT_BASE_ADDR = 20'h0_00c0;
   localparam logic [1:0] OPT_WDT = 2'h0;
   localparam logic [1:0] OPT_SUP = 2'h1;
   localparam logic [1:0] OPT_OSC = 2'h2;
   localparam logic [1:0] OPT_DBG = 2'h3;
   localparam logic [7:0] OPT_ERASED = 8'hff;

   // Field positions
   localparam int WDT_EN_BIT = 4;
   localparam int WDT_TIME_LSB = 1;
   localparam int WDT_STBY_BIT = 0;
   localparam int TH_LSB = 2;
   localparam int PIN_SEL_BIT = 4;
   localparam int OSC_LSB = 0;
   localparam int DBG_EN_BIT = 7;

   // Bits that must be programmed to fixed values
   localparam logic [7:0] WDT_FIX_MASK = 8'he0;
   localparam logic [7:0] SUP_FIX_MASK = 8'he3;
   localparam logic [7:0] OSC_FIX_MASK = 8'hf8;
   localparam logic [7:0] DBG_PAT_MASK = 8'h7f;
   localparam logic [7:0] DBG_PAT = 8'h05;

   // Oscillator codes: 20, 10, 5, 2.5, 1.25 MHz
   localparam logic [2:0] OSC_CODE_MIN = 3'h1;
   localparam logic [2:0] OSC_CODE_MAX = 3'h5;

   // APB map: register index, byte address is four times it
   localparam int APB_AW = 12;
   localparam logic [7:0] IDX_WDT_OPT = 8'hc0;
   localparam logic [7:0] IDX_SUP_OPT = 8'hc1;
   localparam logic [7:0] IDX_OSC_OPT = 8'hc2;
   localparam logic [7:0] IDX_DBG_OPT = 8'hc3;
   localparam logic [7:0] IDX_RESET_SRC = 8'hc4;
   localparam logic [7:0] IDX_EVT_STAT = 8'hc5;
   localparam logic [7:0] IDX_EVT_MASK = 8'hc6;
   localparam logic [7:0] IDX_WDT_CTRL = 8'hc7;

   // Reset source register layout
   localparam int RS_TRAP = 7;
   localparam int RS_WDT = 4;
   localparam int RS_SUPPLY = 0;

   // Event status and mask layout
   localparam int EV_W = 3;
   localparam int EV_WDT_INTERVAL = 0;
   localparam int EV_LOAD_DONE = 1;
   localparam int EV_BAD_OPTION = 2;
   localparam logic [EV_W-1:0] EV_MASK_RESET = 3'h0;

   localparam int CTRL_IRQ_MASK_BIT = 0;
   localparam logic CTRL_IRQ_MASK_RESET = 1'b0;

   // Oscillator accuracy wait after supply release
   localparam int CLK_NS = 10;
   localparam int OSC_STAB_NS = 10000;
   localparam int STAB_CYC = (OSC_STAB_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] STAB_LAST = CNT_W'(STAB_CYC - 1);

   typedef enum logic [3:0] {
      ST_HOLD  = 4'b0001,
      ST_FETCH = 4'b0010,
      ST_STAB  = 4'b0100,
      ST_RUN   = 4'b1000
   } seq_state_t;

   // Watchdog exponent per time-select code
   function automatic logic [4:0] wdtExp(input logic [2:0] code);
      logic [4:0] e;
      e = 5'h06;
      case (code)
         3'h0: e = 5'h06;
         3'h1: e = 5'h07;
         3'h2: e = 5'h08;
         3'h3: e = 5'h09;
         3'h4: e = 5'h0b;
         3'h5: e = 5'h0d;
         3'h6: e = 5'h0e;
         3'h7: e = 5'h10;
         default: e = 5'h06;
      endcase
      return e;
   endfunction

endpackage

// file: hw/option_byte_supply_reset_cfg.sv
/*
 Option byte loader and supply-monitor reset sequencer with APB registers.
 Assumes option storage answers a one-cycle read request with a data valid
 pulse, comparators and retention detector are asynchronous levels, and
 pin, trap and watchdog reset events are one-cycle pulses on mclk.
*/
// What this block does
// - Each rst or supply-monitor reset fetches option bytes C0 to C3 and applies them
// - Hold internal reset from power-on until rising comparator reports ok
// - Falling comparator below threshold while running reasserts reset
// - A supply-monitor reset sets bit 0 of the reset source register
// - Reset source flags survive rst and supply resets; lost on read, pin reset or retention loss
// - Threshold field bits 3:2 of byte C1 picks rise/fall pair
// - Reset pin select bit: 0 port and key input, 1 reset with pull-up
// - Watchdog enable bit starts or leaves stopped the counter after reset
// - Watchdog time code selects exponent; overflow and 0.75 interval
// - Standby bit 0 stops watchdog in halt and stop, 1 keeps counting
// - Interval interrupt fires each interval unless the mask bit is set
// - Debug byte bit 7 enables debug; bits 6:0 hold 0000101
// - Failed debug authentication never erases flash
// - Release waits for oscillator accuracy after supply release
// - Reading reset source, pin reset or retention loss clears flags
`timescale 1ns/100ps
module option_byte_supply_reset_cfg (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [opt_cfg_pkg::APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic optRdEn,
   output logic [19:0] optAddr,
   input wire logic [7:0] optRdData,
   input wire logic optRdValid,
   input wire logic supplyAboveRise,
   input wire logic supplyBelowFall,
   input wire logic retentionLost,
   input wire logic extPinReset,
   input wire logic trapReset,
   input wire logic wdtOverflowReset,
   input wire logic inStandby,
   input wire logic [15:0] wdtCount,
   output logic internalReset,
   output logic wdtEnable,
   output logic wdtStandbyRun,
   output logic wdtCountRun,
   output logic [15:0] wdtOverflowCount,
   output logic wdtIntervalIrq,
   output logic [1:0] thresholdSel,
   output logic resetPinIsReset,
   output logic resetPullupEn,
   output logic portKeyEnable,
   output logic [2:0] oscFreqSel,
   output logic oscSelValid,
   output logic debugEnable,
   output logic debugEraseOnAuthFail
);
   import opt_cfg_pkg::*;

   // Three-stage input filters for asynchronous levels
   localparam int NSYNC = 3;
   logic [NSYNC-1:0] asyncIn;
   logic [NSYNC-1:0] syncA, syncB, syncC, filt, next_filt;
   logic riseOk, fallLow, retLost;
   assign asyncIn = {retentionLost, supplyBelowFall, supplyAboveRise};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : gFilt
         always_comb begin
            next_filt[g] = (syncB[g] == syncC[g]) ? syncC[g] : filt[g];
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (rst) begin
         syncA <= '0;
         syncB <= '0;
         syncC <= '0;
         filt <= '0;
      end else begin
         syncA <= asyncIn;
         syncB <= syncA;
         syncC <= syncB;
         filt <= next_filt;
      end
   end
   assign riseOk = filt[0];
   assign fallLow = filt[1];
   assign retLost = filt[2];

   // Reset sequencer and option latch
   seq_state_t state, next_state;
   logic [1:0] idx, next_idx;
   logic pending, next_pending;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [7:0] opt [4];
   logic [7:0] next_opt [4];
   logic next_optRdEn, next_internalReset;
   logic [4:0] expReg, next_expReg;
   logic [15:0] intervalCount, next_intervalCount;
   logic [15:0] next_wdtOverflowCount;
   logic [16:0] powN;
   logic sporEvent, loadDone, badOption;

   always_comb begin
      next_state = state;
      next_idx = idx;
      next_pending = pending;
      next_cnt = cnt;
      next_opt = opt;
      next_optRdEn = 1'b0;
      next_expReg = expReg;
      next_intervalCount = intervalCount;
      next_wdtOverflowCount = wdtOverflowCount;
      sporEvent = 1'b0;
      loadDone = 1'b0;
      powN = 17'h0_0001 << expReg;
      unique case (state)
         ST_HOLD: begin
            if (riseOk && !fallLow) begin
               next_state = ST_FETCH;
               next_idx = OPT_WDT;
               next_pending = 1'b0;
            end
         end
         ST_FETCH: begin
            if (!pending) begin
               next_optRdEn = 1'b1;
               next_pending = 1'b1;
            end else if (optRdValid) begin
               next_opt[idx] = optRdData;
               next_pending = 1'b0;
               if (idx == OPT_DBG) begin
                  next_state = ST_STAB;
                  next_cnt = '0;
                  next_expReg = wdtExp(opt[OPT_WDT][WDT_TIME_LSB +: 3]);
               end else begin
                  next_idx = idx + 2'h1;
               end
            end
         end
         ST_STAB: begin
            // Exponent is latched; derive the two watchdog counts
            next_wdtOverflowCount = 16'(powN - 17'h0_0001);
            next_intervalCount = 16'((powN >> 1) + (powN >> 2));
            next_cnt = cnt + CNT_W'(1);
            if (cnt == STAB_LAST) begin
               next_state = ST_RUN;
               loadDone = 1'b1;
            end
         end
         ST_RUN: begin
         end
      endcase
      if (fallLow && state != ST_HOLD) begin
         next_state = ST_HOLD;
         next_pending = 1'b0;
         sporEvent = 1'b1;
      end
      next_internalReset = (next_state != ST_RUN);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= ST_HOLD;
         idx <= OPT_WDT;
         pending <= 1'b0;
         cnt <= '0;
         for (int i = 0; i < 4; i++) begin
            opt[i] <= OPT_ERASED;
         end
         optRdEn <= 1'b0;
         internalReset <= 1'b1;
         expReg <= 5'h06;
         intervalCount <= 16'h0000;
         wdtOverflowCount <= 16'h0000;
      end else begin
         state <= next_state;
         idx <= next_idx;
         pending <= next_pending;
         cnt <= next_cnt;
         opt <= next_opt;
         optRdEn <= next_optRdEn;
         internalReset <= next_internalReset;
         expReg <= next_expReg;
         intervalCount <= next_intervalCount;
         wdtOverflowCount <= next_wdtOverflowCount;
      end
   end
   assign optAddr = OPT_BASE_ADDR + 20'(idx);

   // Decoded fields straight from the latched bytes
   assign wdtEnable = opt[OPT_WDT][WDT_EN_BIT];
   assign wdtStandbyRun = opt[OPT_WDT][WDT_STBY_BIT];
   assign wdtCountRun = !internalReset && wdtEnable
      && (!inStandby || wdtStandbyRun);
   assign thresholdSel = opt[OPT_SUP][TH_LSB +: 2];
   assign resetPinIsReset = opt[OPT_SUP][PIN_SEL_BIT];
   assign resetPullupEn = opt[OPT_SUP][PIN_SEL_BIT];
   assign portKeyEnable = !opt[OPT_SUP][PIN_SEL_BIT];
   assign oscFreqSel = opt[OPT_OSC][OSC_LSB +: 3];
   assign oscSelValid = (oscFreqSel >= OSC_CODE_MIN)
      && (oscFreqSel <= OSC_CODE_MAX);
   assign debugEnable = opt[OPT_DBG][DBG_EN_BIT];
   assign debugEraseOnAuthFail = 1'b0;

   // Barred combinations and unprogrammed fixed bits
   assign badOption = (!wdtEnable && wdtStandbyRun)
      || ((opt[OPT_WDT] & WDT_FIX_MASK) != WDT_FIX_MASK)
      || ((opt[OPT_SUP] & SUP_FIX_MASK) != SUP_FIX_MASK)
      || ((opt[OPT_OSC] & OSC_FIX_MASK) != OSC_FIX_MASK)
      || ((opt[OPT_DBG] & DBG_PAT_MASK) != DBG_PAT)
      || !oscSelValid;

   // APB decode
   function automatic logic [8:0] decodeIdx(
      input logic [APB_AW-1:0] a);
      logic hit;
      hit = (a[1:0] == 2'h0) && (a[APB_AW-1:10] == 2'h0)
         && (a[9:2] >= IDX_WDT_OPT) && (a[9:2] <= IDX_WDT_CTRL);
      return {hit, a[9:2]};
   endfunction

   logic [8:0] dec;
   logic setupPh, accessPh, rdDone, wrDone, badAccess;
   logic rdResetSrc, rdEvtStat;
   assign dec = decodeIdx(paddr);
   assign setupPh = psel && !penable;
   assign accessPh = psel && penable;
   assign badAccess = !dec[8] || (pwrite && dec[7:0] != IDX_EVT_MASK
      && dec[7:0] != IDX_WDT_CTRL);
   assign pready = 1'b1;
   assign pslverr = accessPh && badAccess;
   assign rdDone = accessPh && !pwrite && dec[8];
   assign wrDone = accessPh && pwrite && !badAccess;
   assign rdResetSrc = rdDone && dec[7:0] == IDX_RESET_SRC;
   assign rdEvtStat = rdDone && dec[7:0] == IDX_EVT_STAT;

   // Reset source flags: no rst, so they ride through rst and supply resets
   logic flagTrap, flagWdt, flagSupply;
   logic next_flagTrap, next_flagWdt, next_flagSupply;
   logic flagClear;
   always_comb begin
      flagClear = rdResetSrc || extPinReset || retLost;
      next_flagTrap = (flagTrap && !flagClear) || trapReset;
      next_flagWdt = (flagWdt && !flagClear) || wdtOverflowReset;
      next_flagSupply = (flagSupply && !flagClear) || sporEvent;
   end
   always_ff @(posedge mclk) begin
      flagTrap <= next_flagTrap;
      flagWdt <= next_flagWdt;
      flagSupply <= next_flagSupply;
   end

   // Registers, events and interrupt
   logic [EV_W-1:0] evtStat, next_evtStat, evtMask, next_evtMask, evtSet;
   logic irqMask, next_irqMask, intervalHit, next_wdtIntervalIrq;
   logic [31:0] next_prdata;
   always_comb begin
      intervalHit = wdtCountRun && (wdtCount == intervalCount);
      next_wdtIntervalIrq = intervalHit && !irqMask;
      evtSet = '0;
      evtSet[EV_WDT_INTERVAL] = next_wdtIntervalIrq;
      evtSet[EV_LOAD_DONE] = loadDone;
      evtSet[EV_BAD_OPTION] = loadDone && badOption;
      next_evtStat = (rdEvtStat ? '0 : evtStat) | evtSet;
      next_evtMask = evtMask;
      next_irqMask = irqMask;
      if (wrDone && dec[7:0] == IDX_EVT_MASK) begin
         next_evtMask = pwdata[EV_W-1:0];
      end
      if (wrDone && dec[7:0] == IDX_WDT_CTRL) begin
         next_irqMask = pwdata[CTRL_IRQ_MASK_BIT];
      end
      next_prdata = prdata;
      if (setupPh && !dec[8]) begin
         next_prdata = 32'h0000_0000;
      end else if (setupPh) begin
         next_prdata = 32'h0000_0000;
         case (dec[7:0])
            IDX_WDT_OPT: next_prdata[7:0] = opt[OPT_WDT];
            IDX_SUP_OPT: next_prdata[7:0] = opt[OPT_SUP];
            IDX_OSC_OPT: next_prdata[7:0] = opt[OPT_OSC];
            IDX_DBG_OPT: next_prdata[7:0] = opt[OPT_DBG];
            IDX_RESET_SRC: begin
               next_prdata[RS_TRAP] = flagTrap;
               next_prdata[RS_WDT] = flagWdt;
               next_prdata[RS_SUPPLY] = flagSupply;
            end
            IDX_EVT_STAT: next_prdata[EV_W-1:0] = evtStat;
            IDX_EVT_MASK: next_prdata[EV_W-1:0] = evtMask;
            IDX_WDT_CTRL: next_prdata[CTRL_IRQ_MASK_BIT] = irqMask;
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         evtStat <= '0;
         evtMask <= EV_MASK_RESET;
         irqMask <= CTRL_IRQ_MASK_RESET;
         wdtIntervalIrq <= 1'b0;
         prdata <= 32'h0000_0000;
         irq <= 1'b0;
      end else begin
         evtStat <= next_evtStat;
         evtMask <= next_evtMask;
         irqMask <= next_irqMask;
         wdtIntervalIrq <= next_wdtIntervalIrq;
         prdata <= next_prdata;
         irq <= |(next_evtStat & next_evtMask);
      end
   end

   // Checks
   a_fetch_first_byte: assert property (@(posedge mclk) disable iff (rst)
      (state == ST_HOLD && next_state == ST_FETCH)
      |=> ##1 (optRdEn && optAddr == OPT_BASE_ADDR))
      else $error("option fetch did not start at first byte");

   a_hold_until_rise: assert property (@(posedge mclk) disable iff (rst)
      (!riseOk && state == ST_HOLD) |=> internalReset)
      else $error("internal reset released before rise threshold");

   a_fall_resets: assert property (@(posedge mclk) disable iff (rst)
      (state == ST_RUN && fallLow) |=> (internalReset && flagSupply))
      else $error("falling supply did not reset and flag");

   a_supply_flag_set: assert property (@(posedge mclk) disable iff (rst)
      sporEvent |=> flagSupply)
      else $error("supply reset flag not set");

   a_flags_survive: assert property (@(posedge mclk) disable iff (rst)
      ($fell(rst) && !$past(flagClear) && !$past(trapReset)
       && !$past(wdtOverflowReset) && !$past(sporEvent))
      |-> ({flagTrap, flagWdt, flagSupply}
           == $past({flagTrap, flagWdt, flagSupply})))
      else $error("reset source flags lost across reset");

   a_standby_stop: assert property (@(posedge mclk) disable iff (rst)
      (inStandby && !wdtStandbyRun) || !wdtEnable |-> !wdtCountRun)
      else $error("watchdog runs while it must be stopped");

   a_interval_irq: assert property (@(posedge mclk) disable iff (rst)
      (wdtCountRun && wdtCount == intervalCount && !irqMask)
      |=> (wdtIntervalIrq && evtStat[EV_WDT_INTERVAL]))
      else $error("interval interrupt missed");

   a_stab_wait: assert property (@(posedge mclk) disable iff (rst)
      $fell(internalReset) |-> ($past(state) == ST_STAB
      && $past(cnt) == STAB_LAST))
      else $error("release before oscillator wait ended");

   a_read_clears: assert property (@(posedge mclk) disable iff (rst)
      (rdResetSrc && !trapReset && !wdtOverflowReset && !sporEvent)
      |=> !(flagTrap || flagWdt || flagSupply))
      else $error("reset source read did not clear flags");

   a_fields_stable: assert property (@(posedge mclk) disable iff (rst)
      (state == ST_RUN && $past(state) == ST_RUN)
      |-> ($stable(opt[OPT_WDT]) && $stable(opt[OPT_SUP])
           && $stable(opt[OPT_OSC]) && $stable(opt[OPT_DBG])))
      else $error("option fields changed while running");

   a_no_erase: assert property (@(posedge mclk) disable iff (rst)
      debugEnable |-> !debugEraseOnAuthFail)
      else $error("erase requested on debug authentication failure");

endmodule

// file: tb/opt_store_model.sv
/*
 Behavioural option storage: answers each read request after a chosen
 latency with one byte of the programmed image.
 Assumes one request pending at a time, all on the rising edge of mclk.
*/
`timescale 1ns/100ps
module opt_store_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic optRdEn,
   input wire logic [19:0] optAddr,
   input wire logic [31:0] image,
   input wire logic [3:0] lat,
   output logic [7:0] optRdData,
   output logic optRdValid
);
   logic busy;
   logic [3:0] waitCnt;
   logic [1:0] idx;

   always_ff @(posedge mclk) begin
      optRdValid <= 1'b0;
      // Data lines change every cycle outside reset and a valid pulse
      optRdData <= ~optRdData;
      if (rst) begin
         busy <= 1'b0;
         optRdData <= 8'h5a;
      end else if (optRdEn) begin
         busy <= 1'b1;
         idx <= optAddr[1:0];
         waitCnt <= lat;
      end else if (busy && waitCnt == 4'h0) begin
         busy <= 1'b0;
         optRdValid <= 1'b1;
         optRdData <= image[8*idx +: 8];
      end else if (busy) begin
         waitCnt <= waitCnt - 4'h1;
      end
   end
endmodule

// file: tb/option_byte_supply_reset_cfg_tb_top.sv
/*
 Self-checking bench: reloads random option images through supply drops
 and checks decoded fields, registers, reset flags and events.
 Assumes zero-wait APB and the option storage model beside the block.
*/
`timescale 1ns/100ps
module option_byte_supply_reset_cfg_tb_top;
   import opt_cfg_pkg::*;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, image, rd;
   logic optRdEn, optRdValid, supplyAboveRise, supplyBelowFall;
   logic retentionLost, extPinReset, trapReset, wdtOverflowReset, inStandby;
   logic [19:0] optAddr;
   logic [7:0] optRdData;
   logic [15:0] wdtCount, wdtOverflowCount;
   logic internalReset, wdtEnable, wdtStandbyRun, wdtCountRun;
   logic wdtIntervalIrq, resetPinIsReset, resetPullupEn, portKeyEnable;
   logic oscSelValid, debugEnable, debugEraseOnAuthFail;
   logic [1:0] thresholdSel;
   logic [2:0] oscFreqSel, tc;
   logic [3:0] lat;
   int error_cnt, check_count, cyc, sinceValid, fetchIdx, pulses, p0;
   int expTab[8] = '{6, 7, 8, 9, 11, 13, 14, 16};

   option_byte_supply_reset_cfg dut_u (.mclk(mclk), .rst(rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .optRdEn(optRdEn), .optAddr(optAddr),
      .optRdData(optRdData), .optRdValid(optRdValid),
      .supplyAboveRise(supplyAboveRise), .supplyBelowFall(supplyBelowFall),
      .retentionLost(retentionLost), .extPinReset(extPinReset),
      .trapReset(trapReset), .wdtOverflowReset(wdtOverflowReset),
      .inStandby(inStandby), .wdtCount(wdtCount),
      .internalReset(internalReset), .wdtEnable(wdtEnable),
      .wdtStandbyRun(wdtStandbyRun), .wdtCountRun(wdtCountRun),
      .wdtOverflowCount(wdtOverflowCount), .wdtIntervalIrq(wdtIntervalIrq),
      .thresholdSel(thresholdSel), .resetPinIsReset(resetPinIsReset),
      .resetPullupEn(resetPullupEn), .portKeyEnable(portKeyEnable),
      .oscFreqSel(oscFreqSel), .oscSelValid(oscSelValid),
      .debugEnable(debugEnable),
      .debugEraseOnAuthFail(debugEraseOnAuthFail));

   opt_store_model store_u (.mclk(mclk), .rst(rst), .optRdEn(optRdEn),
      .optAddr(optAddr), .image(image), .lat(lat),
      .optRdData(optRdData), .optRdValid(optRdValid));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic check(input string nm, input logic [31:0] seen,
         input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      sinceValid <= optRdValid ? 0 : sinceValid + 1;
      if (wdtIntervalIrq === 1'b1) pulses <= pulses + 1;
      if (optRdEn === 1'b1) begin
         check("optAddr", 32'(optAddr), 32'(OPT_BASE_ADDR) + fetchIdx);
         fetchIdx <= fetchIdx + 1;
      end
      if (internalReset === 1'b0) fetchIdx <= 0;
      if (cyc == 40000) begin
         error_cnt++;
         final_report();
      end
   end

   task automatic apb(input logic wr, input logic [7:0] idx,
         input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= APB_AW'({idx, 2'b00});
      pwrite <= wr;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) error_cnt++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic pulseSrc(input int k);
      @(posedge mclk);
      trapReset <= (k == 0);
      wdtOverflowReset <= (k == 1);
      extPinReset <= (k == 2);
      @(posedge mclk);
      trapReset <= 1'b0;
      wdtOverflowReset <= 1'b0;
      extPinReset <= 1'b0;
   endtask

   task automatic waitIr(input logic v, input int lim);
      int n;
      n = 0;
      while (internalReset !== v && n < lim) begin
         @(negedge mclk);
         n++;
      end
      check("internalReset", 32'(internalReset), 32'(v));
   endtask

   task automatic checkFields();
      logic [2:0] osc;
      osc = image[18:16];
      check("wdtEnable", 32'(wdtEnable), 32'(image[4]));
      check("wdtStandbyRun", 32'(wdtStandbyRun), 32'(image[0]));
      check("ovfCount", 32'(wdtOverflowCount),
         (1 << expTab[image[3:1]]) - 1);
      check("thresholdSel", 32'(thresholdSel), 32'(image[11:10]));
      check("pinIsReset", 32'(resetPinIsReset), 32'(image[12]));
      check("pullupEn", 32'(resetPullupEn), 32'(image[12]));
      check("portKeyEn", 32'(portKeyEnable), 32'(!image[12]));
      check("oscFreqSel", 32'(oscFreqSel), 32'(osc));
      check("oscSelValid", 32'(oscSelValid), 32'(osc >= 1 && osc <= 5));
      check("debugEnable", 32'(debugEnable), 32'(image[31]));
      check("eraseOnFail", 32'(debugEraseOnAuthFail), 0);
      for (int k = 0; k < 4; k++) begin
         apb(1'b0, IDX_WDT_OPT + 8'(k), 0);
         check("optionReg", rd, 32'(image[8*k +: 8]));
      end
   endtask

   // Unassigned bits at 1 and the debug pattern kept; the prohibited
   // watchdog pair is left to chance on purpose
   function automatic logic [31:0] randImg();
      logic [31:0] r;
      r = $urandom;
      return {r[31], 7'h05, 5'h1f, r[18:16], 3'h7, r[12:10], 2'h3, 3'h7,
         r[4:0]};
   endfunction

   task automatic reload(input logic [31:0] img);
      logic [2:0] st, m;
      pulseSrc(0);
      @(posedge mclk);
      supplyAboveRise <= 1'b0;
      supplyBelowFall <= 1'b1;
      waitIr(1'b1, 10);
      @(posedge mclk);
      image <= img;
      lat <= 4'($urandom_range(0, 5));
      inStandby <= 1'($urandom);
      repeat (8) @(posedge mclk);
      supplyBelowFall <= 1'b0;
      supplyAboveRise <= 1'b1;
      waitIr(1'b0, 3000);
      check("stabWait", 32'(sinceValid >= STAB_CYC - 2 &&
         sinceValid <= STAB_CYC + 4), 1);
      check("countRun", 32'(wdtCountRun),
         32'(img[4] & (!inStandby | img[0])));
      checkFields();
      apb(1'b0, IDX_RESET_SRC, 0);
      check("resetSrc", rd, 32'h0000_0081);
      apb(1'b0, IDX_RESET_SRC, 0);
      check("resetSrcClr", rd, 0);
      st = {(!img[4] && img[0]) || img[18:16] == 0 || img[18:16] > 5, 2'b10};
      m = 3'($urandom_range(0, 7));
      apb(1'b1, IDX_EVT_MASK, 32'(m));
      repeat (2) @(negedge mclk);
      check("irq", 32'(irq), 32'(|(st & m)));
      apb(1'b0, IDX_EVT_STAT, 0);
      check("evtStat", rd, 32'(st));
      repeat (2) @(negedge mclk);
      check("irqClr", 32'(irq), 0);
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      retentionLost = 1'b1;
      supplyAboveRise = 1'b0;
      supplyBelowFall = 1'b1;
      extPinReset = 1'b1;
      trapReset = 1'b0;
      wdtOverflowReset = 1'b0;
      inStandby = 1'b0;
      wdtCount = 16'h0000;
      image = 32'h85fd_e7f7;
      lat = 4'h2;
      void'($urandom(97264));
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      extPinReset <= 1'b0;
      repeat (3) @(posedge mclk);
      retentionLost <= 1'b0;
      repeat (20) @(negedge mclk);
      check("porHold", 32'(internalReset), 1);
      @(posedge mclk);
      supplyBelowFall <= 1'b0;
      supplyAboveRise <= 1'b1;
      waitIr(1'b0, 3000);
      checkFields();
      apb(1'b0, IDX_RESET_SRC, 0);
      check("resetSrcPor", rd, 0);
      apb(1'b0, IDX_EVT_STAT, 0);
      for (int i = 0; i < 6; i++) reload(randImg());
      pulseSrc(1);
      pulseSrc(2);
      apb(1'b0, IDX_RESET_SRC, 0);
      check("pinClear", rd, 0);
      pulseSrc(1);
      apb(1'b0, IDX_RESET_SRC, 0);
      check("wdtFlag", rd, 32'h0000_0010);
      pulseSrc(0);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      waitIr(1'b0, 3000);
      apb(1'b0, IDX_RESET_SRC, 0);
      check("rstKeep", rd, 32'h0000_0080);
      apb(1'b0, IDX_EVT_STAT, 0);
      pulseSrc(0);
      @(posedge mclk);
      retentionLost <= 1'b1;
      repeat (6) @(posedge mclk);
      retentionLost <= 1'b0;
      repeat (6) @(posedge mclk);
      apb(1'b0, IDX_RESET_SRC, 0);
      check("retClear", rd, 0);
      apb(1'b0, 8'hc8, 0);
      check("unmappedErr", 32'(err), 1);
      check("unmappedData", rd, 0);
      apb(1'b1, IDX_WDT_OPT, 0);
      check("roErr", 32'(err), 1);
      apb(1'b0, IDX_WDT_OPT, 0);
      check("roHold", rd, 32'(image[7:0]));
      tc = 3'($urandom_range(0, 7));
      reload({8'h85, 8'hf9, 8'he3, 3'h7, 1'b1, tc, 1'b1});
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, IDX_WDT_CTRL, 32'(k));
         p0 = pulses;
         @(posedge mclk);
         wdtCount <= 16'(3 << (expTab[tc] - 2));
         @(posedge mclk);
         wdtCount <= 16'h0000;
         repeat (4) @(negedge mclk);
         check("intervalIrq", pulses - p0, 32'(k == 0));
      end
      apb(1'b0, IDX_WDT_CTRL, 0);
      check("ctrlReg", rd, 32'h0000_0001);
      apb(1'b0, IDX_EVT_STAT, 0);
      check("intervalStat", rd, 32'h0000_0001);
      final_report();
   end
endmodule
